// ---- dag_core_model.sv ----
// Core-side model: working registers that feed the generator requests.
// Assumes write-back arrives on the response one cycle after a request.
`timescale 1ns/1ps
module dag_core_model
(
	input  wire logic              clk,
	input  wire logic              nrst,
	input  wire logic              ld_en,
	input  wire logic [3:0]        ld_sel,
	input  wire logic [15:0]       ld_val,
	input  wire dag_pkg::dag_req_t cmd_wr,
	input  wire dag_pkg::dag_req_t cmd_rd,
	input  wire dag_pkg::dag_rsp_t wr_rsp,
	input  wire dag_pkg::dag_rsp_t rd_rsp,
	output dag_pkg::dag_req_t      wr_req,
	output dag_pkg::dag_req_t      rd_req
);
	logic [15:0] wreg [16];

	// Pointer value always comes from the register file
	always_comb
	begin
		wr_req = cmd_wr;
		wr_req.wval = wreg[cmd_wr.wsel];
		rd_req = cmd_rd;
		rd_req.wval = wreg[cmd_rd.wsel];
	end

	// No forwarding: requests on one pointer need a cycle between them
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			for (int i = 0; i < 16; i++)
				wreg[i] <= 16'h0000;
		end
		else if (ld_en)
			wreg[ld_sel] <= ld_val;
		else
		begin
			if (wr_rsp.valid && wr_rsp.wb_en)
				wreg[wr_rsp.wb_sel] <= wr_rsp.wb_val;
			if (rd_rsp.valid && rd_rsp.wb_en)
				wreg[rd_rsp.wb_sel] <= rd_rsp.wb_val;
		end
	end
endmodule : dag_core_model

// ---- dag_pkg.sv ----
// Package for the data address generator: register map, fields, modes.
// Assumes a 16-bit core with 16 working registers and an APB register port.
package dag_pkg;
	localparam int unsigned DAG_AW   = 16;
	localparam logic [7:0] OFF_BREV  = 8'h00; // Bit-reverse control
	localparam logic [7:0] OFF_CIRC  = 8'h04; // Circular addressing control
	localparam logic [7:0] OFF_XSTA  = 8'h08; // Modulo start, X generator
	localparam logic [7:0] OFF_XEND  = 8'h0c; // Modulo end, X generator
	localparam logic [7:0] OFF_STAT  = 8'h10; // Last write-side status
	localparam int unsigned BITREV_ENABLE_BIT = 15;
	localparam int unsigned XB_MSB   = 14;
	localparam int unsigned CIRC_EN_BIT = 15;
	localparam int unsigned SEL_LSB  = 0;
	localparam int unsigned SEL_MSB  = 3;
	localparam logic [3:0] SP_SEL    = 4'hf;
	localparam logic [15:0] BREV_RST = 16'h0000;
	localparam logic [15:0] CIRC_RST = 16'h000f;
	localparam logic [15:0] STAT_BREV = 16'h0001;
	localparam logic [15:0] STAT_WRAP = 16'h0002;
	localparam logic [15:0] STAT_WB   = 16'h0004;
	localparam logic [15:0] WORD_MASK = 16'hfffe;
	localparam logic [15:0] STEP_BYTE = 16'h0001;
	localparam logic [15:0] STEP_WORD = 16'h0002;
	localparam logic [15:0] MOD_RST   = 16'h0000;

	typedef enum logic [2:0] {
		DAG_IND,
		DAG_POST_INC,
		DAG_POST_DEC,
		DAG_PRE_INC,
		DAG_PRE_DEC,
		DAG_REG_OFS
	} dag_mode_t;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic        byte_acc;
		dag_mode_t   mode;
		logic [3:0]  wsel;
		logic [15:0] wval;
		logic [15:0] ofs;
	} dag_req_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] ea;
		logic        wb_en;
		logic [3:0]  wb_sel;
		logic [15:0] wb_val;
	} dag_rsp_t;
endpackage : dag_pkg

// ---- dag_top.sv ----
// Effective address generation for the X read and write paths, with
// modulo correction and bit-reversed write addressing; APB register port.
// Assumes the core presents one request per cycle and uses the result
// one cycle later; the working register file lives in the core.
`timescale 1ns/1ps
module dag_top
(
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [7:0]       paddr,
	input  wire logic [31:0]      pwdata,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	input  wire dag_pkg::dag_req_t rd_req,
	input  wire dag_pkg::dag_req_t wr_req,
	output dag_pkg::dag_rsp_t     rd_rsp,
	output dag_pkg::dag_rsp_t     wr_rsp
);
	logic [15:0] bitrev_control;
	logic [15:0] circular_addr_control;
	logic [15:0] mod_start;
	logic [15:0] mod_end;
	logic [15:0] status;

	// Reverse-carry add: carries ripple from msb toward lsb
	function automatic logic [15:0] rev_add(input logic [15:0] a,
		input logic [15:0] b);
		logic [15:0] s;
		logic        c;
		c = 1'b0;
		s = '0;
		for (int i = 15; i >= 0; i--)
		begin
			s[i] = a[i] ^ b[i] ^ c;
			c = (a[i] & b[i]) | (c & (a[i] ^ b[i]));
		end
		return s;
	endfunction : rev_add

	// Step size and direction of a mode
	function automatic logic [15:0] step(input dag_pkg::dag_req_t r);
		logic [15:0] sz;
		sz = r.byte_acc ? dag_pkg::STEP_BYTE : dag_pkg::STEP_WORD;
		unique case (r.mode)
			dag_pkg::DAG_POST_INC, dag_pkg::DAG_PRE_INC: step = sz;
			dag_pkg::DAG_POST_DEC, dag_pkg::DAG_PRE_DEC: step = -sz;
			dag_pkg::DAG_REG_OFS: step = r.ofs;
			default: step = 16'h0000;
		endcase
	endfunction : step

	// Inequality against the bounds so a jump past either end wraps
	function automatic logic [15:0] wrap(input logic [15:0] a,
		input logic [15:0] st, input logic [15:0] en,
		input logic inc, input logic on);
		logic [15:0] len;
		len = en - st + 16'h0001;
		if (on && inc && a > en)
			wrap = a - len;
		else if (on && !inc && a < st)
			wrap = a + len;
		else
			wrap = a;
	endfunction : wrap

	function automatic logic is_pre(input dag_pkg::dag_mode_t m);
		return m == dag_pkg::DAG_PRE_INC || m == dag_pkg::DAG_PRE_DEC;
	endfunction : is_pre

	function automatic logic modifies(input dag_pkg::dag_mode_t m);
		return m != dag_pkg::DAG_IND && m != dag_pkg::DAG_REG_OFS;
	endfunction : modifies

	function automatic logic incs(input dag_pkg::dag_req_t r);
		return r.mode == dag_pkg::DAG_PRE_INC
			|| r.mode == dag_pkg::DAG_POST_INC
			|| (r.mode == dag_pkg::DAG_REG_OFS && !r.ofs[15]);
	endfunction : incs

	// Modulo on every register when enabled, except writes while reversal is active;
	// the control field's low nibble selects only the pointer for reversed write addressing
	wire [3:0]  sel      = circular_addr_control[dag_pkg::SEL_MSB:
		dag_pkg::SEL_LSB];
	wire        circ_on  = circular_addr_control[dag_pkg::CIRC_EN_BIT];
	wire        brev_bit = bitrev_control[dag_pkg::BITREV_ENABLE_BIT];
	wire [14:0] xb       = bitrev_control[dag_pkg::XB_MSB:0];
	wire [15:0] xb_bytes = {xb, 1'b0};

	// Read side: modulo only, never reversed
	wire [15:0] rd_sum  = rd_req.wval + step(rd_req);
	wire [15:0] rd_mod  = wrap(rd_sum, mod_start, mod_end, incs(rd_req),
		circ_on);
	wire [15:0] rd_ea   = (is_pre(rd_req.mode)
		|| rd_req.mode == dag_pkg::DAG_REG_OFS) ? rd_mod : rd_req.wval;

	// Write side reversed mode
	wire wr_incmode = wr_req.mode == dag_pkg::DAG_PRE_INC
		|| wr_req.mode == dag_pkg::DAG_POST_INC;
	wire brev_act = sel != dag_pkg::SP_SEL && brev_bit && wr_incmode
		&& wr_req.wsel == sel && !wr_req.byte_acc
		&& wr_req.write;
	// Base stays in normal order; the modifier is added with reversed carry
	wire [15:0] wr_rev  = rev_add(wr_req.wval, xb_bytes)
		& dag_pkg::WORD_MASK;
	wire [15:0] wr_sum  = wr_req.wval + step(wr_req);
	wire [15:0] wr_mod  = wrap(wr_sum, mod_start, mod_end, incs(wr_req),
		circ_on && !brev_act);
	wire [15:0] wr_next = brev_act ? wr_rev : wr_mod;
	wire [15:0] wr_base = brev_act ? (wr_req.wval & dag_pkg::WORD_MASK)
		: wr_req.wval;
	wire [15:0] wr_ea   = (is_pre(wr_req.mode)
		|| wr_req.mode == dag_pkg::DAG_REG_OFS) ? wr_next : wr_base;
	wire wr_wrap = wr_mod != wr_sum;

	// APB decode, zero wait states
	wire        apb_wr  = psel && penable && pwrite;
	wire        hit     = paddr == dag_pkg::OFF_BREV
		|| paddr == dag_pkg::OFF_CIRC || paddr == dag_pkg::OFF_XSTA
		|| paddr == dag_pkg::OFF_XEND || paddr == dag_pkg::OFF_STAT;
	logic [15:0] rd_mux;
	always_comb
	begin
		unique case (paddr)
			dag_pkg::OFF_BREV: rd_mux = bitrev_control;
			dag_pkg::OFF_CIRC: rd_mux = circular_addr_control;
			dag_pkg::OFF_XSTA: rd_mux = mod_start;
			dag_pkg::OFF_XEND: rd_mux = mod_end;
			dag_pkg::OFF_STAT: rd_mux = status;
			default:           rd_mux = 16'h0000;
		endcase
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			bitrev_control        <= dag_pkg::BREV_RST;
			circular_addr_control <= dag_pkg::CIRC_RST;
			mod_start             <= dag_pkg::MOD_RST;
			mod_end               <= dag_pkg::MOD_RST;
		end
		else if (apb_wr)
		begin
			unique case (paddr)
				dag_pkg::OFF_BREV: bitrev_control <= pwdata[15:0];
				dag_pkg::OFF_CIRC: circular_addr_control <= pwdata[15:0];
				dag_pkg::OFF_XSTA: mod_start <= pwdata[15:0];
				dag_pkg::OFF_XEND: mod_end <= pwdata[15:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !hit;
			prdata  <= (psel && !penable && !pwrite) ? {16'h0000, rd_mux}
				: 32'h0000_0000;
		end
	end

	// Results registered one cycle after the request
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rd_rsp <= '0;
			wr_rsp <= '0;
			status <= 16'h0000;
		end
		else
		begin
			rd_rsp.valid  <= rd_req.valid;
			rd_rsp.ea     <= rd_ea;
			rd_rsp.wb_en  <= rd_req.valid && modifies(rd_req.mode);
			rd_rsp.wb_sel <= rd_req.wsel;
			rd_rsp.wb_val <= rd_mod;
			wr_rsp.valid  <= wr_req.valid;
			wr_rsp.ea     <= wr_ea;
			wr_rsp.wb_en  <= wr_req.valid && modifies(wr_req.mode);
			wr_rsp.wb_sel <= wr_req.wsel;
			wr_rsp.wb_val <= wr_next;
			if (wr_req.valid)
				status <= (brev_act ? dag_pkg::STAT_BREV : 16'h0000)
					| (wr_wrap ? dag_pkg::STAT_WRAP : 16'h0000)
					| (modifies(wr_req.mode) ? dag_pkg::STAT_WB : 16'h0000);
		end
	end

	a_wb_offset_mode: assert property (@(posedge clk) disable iff (!nrst)
		wr_req.valid && wr_req.mode == dag_pkg::DAG_REG_OFS
		|=> !wr_rsp.wb_en)
		else $error("pointer written back in offset mode");
	a_rev_ea_even: assert property (@(posedge clk) disable iff (!nrst)
		wr_req.valid && brev_act |=> wr_rsp.ea[0] == 1'b0)
		else $error("reversed address not word aligned");
	a_rev_sp_off: assert property (@(posedge clk) disable iff (!nrst)
		sel == dag_pkg::SP_SEL |-> !brev_act)
		else $error("reversal on stack pointer");
	a_rev_byte_off: assert property (@(posedge clk) disable iff (!nrst)
		wr_req.byte_acc |-> !brev_act)
		else $error("reversal on byte access");
	a_rev_next_val: assert property (@(posedge clk) disable iff (!nrst)
		wr_req.valid && brev_act
		|=> wr_rsp.wb_val == (rev_add($past(wr_req.wval), {$past(xb), 1'b0})
		& 16'hfffe))
		else $error("reversed next pointer wrong");
	a_rev_noinc_ofs: assert property (@(posedge clk) disable iff (!nrst)
		wr_req.valid && brev_act && wr_req.mode == dag_pkg::DAG_POST_INC
		|=> wr_rsp.ea == ($past(wr_req.wval) & 16'hfffe))
		else $error("post mode address not pointer");
	a_rd_wrap_up: assert property (@(posedge clk) disable iff (!nrst)
		rd_req.valid && circ_on && incs(rd_req) && rd_sum > mod_end
		|=> rd_rsp.wb_val == $past(rd_sum) - ($past(mod_end)
		- $past(mod_start) + 16'h0001))
		else $error("read side upper wrap wrong");
	a_rd_no_rev: assert property (@(posedge clk) disable iff (!nrst)
		rd_req.valid && !circ_on && rd_req.mode == dag_pkg::DAG_PRE_INC
		|=> rd_rsp.ea == $past(rd_sum))
		else $error("read side altered without modulo");
	a_wr_mod_off: assert property (@(posedge clk) disable iff (!nrst)
		brev_act |-> wr_mod == wr_sum)
		else $error("modulo active during reversal");

	// Bus handshake: one access cycle, and an error only when unmapped
	a_apb_ready_next: assert property (@(posedge clk) disable iff (!nrst)
		psel && !penable |=> pready)
		else $error("no ready after setup");
	a_apb_ready_once: assert property (@(posedge clk) disable iff (!nrst)
		pready |=> !pready)
		else $error("ready held past one cycle");
	a_apb_err_unmap: assert property (@(posedge clk) disable iff (!nrst)
		psel && !penable && !hit |=> pslverr)
		else $error("no error on unmapped offset");
	a_apb_err_mapped: assert property (@(posedge clk) disable iff (!nrst)
		psel && !penable && hit |=> !pslverr)
		else $error("error on mapped offset");
	a_apb_hi_zero: assert property (@(posedge clk) disable iff (!nrst)
		prdata[31:16] == 16'h0000)
		else $error("upper read half not zero");
	a_apb_data_idle: assert property (@(posedge clk) disable iff (!nrst)
		!pready |-> prdata == 32'h0000_0000)
		else $error("read data outside access");
	a_apb_start_wr: assert property (@(posedge clk) disable iff (!nrst)
		apb_wr && paddr == dag_pkg::OFF_XSTA
		|=> mod_start == $past(pwdata[15:0]))
		else $error("modulo start not written");
	a_xb_field: assert property (@(posedge clk) disable iff (!nrst)
		apb_wr && paddr == dag_pkg::OFF_BREV
		|=> xb == $past(pwdata[dag_pkg::XB_MSB:0]))
		else $error("modifier field not taken");

	// Modulo: a zero-length buffer is left to software to avoid
	a_rd_wrap_down: assert property (@(posedge clk) disable iff (!nrst)
		rd_req.valid && circ_on && !incs(rd_req) && rd_sum < mod_start
		|=> rd_rsp.wb_val == $past(rd_sum) + ($past(mod_end)
		- $past(mod_start) + 16'h0001))
		else $error("read side lower wrap wrong");
	a_rd_in_range: assert property (@(posedge clk) disable iff (!nrst)
		rd_req.valid && rd_sum >= mod_start && rd_sum <= mod_end
		|=> rd_rsp.wb_val == $past(rd_sum))
		else $error("in-range address altered");
	a_wr_wrap_up: assert property (@(posedge clk) disable iff (!nrst)
		wr_req.valid && !brev_act && circ_on && incs(wr_req)
		&& wr_sum > mod_end
		|=> wr_rsp.wb_val == $past(wr_sum) - ($past(mod_end)
		- $past(mod_start) + 16'h0001))
		else $error("write side upper wrap wrong");
	a_ofs_ea_wrap: assert property (@(posedge clk) disable iff (!nrst)
		rd_req.valid && circ_on && rd_req.mode == dag_pkg::DAG_REG_OFS
		&& !rd_req.ofs[15] && rd_sum > mod_end
		|=> rd_rsp.ea == $past(rd_sum) - ($past(mod_end)
		- $past(mod_start) + 16'h0001))
		else $error("offset access not corrected");
	a_rd_wb_mod: assert property (@(posedge clk) disable iff (!nrst)
		rd_req.valid && modifies(rd_req.mode) |=> rd_rsp.wb_en)
		else $error("modified pointer not written back");
	a_rd_wb_ofs: assert property (@(posedge clk) disable iff (!nrst)
		rd_req.valid && rd_req.mode == dag_pkg::DAG_REG_OFS
		|=> !rd_rsp.wb_en)
		else $error("pointer written back in offset read");
	a_wb_ind_mode: assert property (@(posedge clk) disable iff (!nrst)
		wr_req.valid && wr_req.mode == dag_pkg::DAG_IND |=> !wr_rsp.wb_en)
		else $error("pointer written back in plain indirect");
	a_rd_mod_brev: assert property (@(posedge clk) disable iff (!nrst)
		rd_req.valid && brev_bit && rd_req.wsel == sel && circ_on
		&& incs(rd_req) && rd_sum > mod_end
		|=> rd_rsp.wb_val == $past(rd_sum) - ($past(mod_end)
		- $past(mod_start) + 16'h0001))
		else $error("read modulo lost on reversed pointer");

	// Reversal: write path only, word data, increment modes
	a_rd_post_ea: assert property (@(posedge clk) disable iff (!nrst)
		rd_req.valid && rd_req.mode == dag_pkg::DAG_POST_INC
		|=> rd_rsp.ea == $past(rd_req.wval))
		else $error("read address not the pointer");
	a_rev_pre_ea: assert property (@(posedge clk) disable iff (!nrst)
		wr_req.valid && brev_act && wr_req.mode == dag_pkg::DAG_PRE_INC
		|=> wr_rsp.ea == (rev_add($past(wr_req.wval), {$past(xb), 1'b0})
		& dag_pkg::WORD_MASK))
		else $error("pre mode reversed address wrong");
	a_byte_norm: assert property (@(posedge clk) disable iff (!nrst)
		wr_req.valid && wr_req.byte_acc && !circ_on
		&& wr_req.mode == dag_pkg::DAG_POST_INC
		|=> wr_rsp.wb_val == $past(wr_req.wval) + dag_pkg::STEP_BYTE)
		else $error("byte access not stepped normally");
	a_rev_dis_norm: assert property (@(posedge clk) disable iff (!nrst)
		wr_req.valid && !brev_bit && !circ_on && !wr_req.byte_acc
		&& wr_req.mode == dag_pkg::DAG_POST_INC
		|=> wr_rsp.wb_val == $past(wr_req.wval) + dag_pkg::STEP_WORD)
		else $error("reversal without enable bit");
	a_rev_sp_norm: assert property (@(posedge clk) disable iff (!nrst)
		wr_req.valid && sel == dag_pkg::SP_SEL && !circ_on
		&& !wr_req.byte_acc && wr_req.mode == dag_pkg::DAG_POST_INC
		|=> wr_rsp.wb_val == $past(wr_req.wval) + dag_pkg::STEP_WORD)
		else $error("reversal on stack pointer select");

	// One answer per request, carrying its pointer select
	a_rd_rsp_valid: assert property (@(posedge clk) disable iff (!nrst)
		rd_req.valid |=> rd_rsp.valid)
		else $error("read request not answered");
	a_wr_rsp_valid: assert property (@(posedge clk) disable iff (!nrst)
		wr_req.valid |=> wr_rsp.valid && wr_rsp.wb_sel == $past(wr_req.wsel))
		else $error("write request not answered");
endmodule : dag_top

// ---- dag_top_bench.sv ----
// Self-checking bench for the address generator and its APB registers.
// Assumes the core model holds the pointers and takes the write-backs.
`timescale 1ns/1ps
module dag_top_bench;
	logic              clk;
	logic              nrst;
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic              pready;
	logic              pslverr;
	logic              rerr;
	logic              ld_en;
	logic [3:0]        ld_sel;
	logic [15:0]       ld_val;
	logic [7:0]        paddr;
	logic [31:0]       pwdata;
	logic [31:0]       prdata;
	logic [31:0]       rdat;
	dag_pkg::dag_req_t cmd_wr;
	dag_pkg::dag_req_t cmd_rd;
	dag_pkg::dag_req_t wr_req;
	dag_pkg::dag_req_t rd_req;
	dag_pkg::dag_rsp_t wr_rsp;
	dag_pkg::dag_rsp_t rd_rsp;
	int                mismatches;
	int                n_compared;

	dag_top DUT (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rd_req(rd_req),
		.wr_req(wr_req), .rd_rsp(rd_rsp), .wr_rsp(wr_rsp));
	dag_core_model core (.clk(clk), .nrst(nrst), .ld_en(ld_en),
		.ld_sel(ld_sel), .ld_val(ld_val), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
		.wr_rsp(wr_rsp), .rd_rsp(rd_rsp), .wr_req(wr_req), .rd_req(rd_req));

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic complete_run;
		if (mismatches == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : complete_run

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	// Reverse-carry add: reverse both, add, reverse the sum back
	function automatic logic [15:0] rev_add(input logic [15:0] a,
		input logic [15:0] b);
		logic [15:0] ra;
		logic [15:0] rb;
		logic [15:0] rs;
		for (int i = 0; i < 16; i++)
		begin
			ra[i] = a[15-i];
			rb[i] = b[15-i];
		end
		rs = ra + rb;
		for (int i = 0; i < 16; i++)
			rev_add[i] = rs[15-i];
	endfunction : rev_add

	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (n >= 20)
		begin
			mismatches++;
			complete_run;
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic ld(input logic [3:0] s, input logic [15:0] v);
		@(posedge clk);
		ld_en <= 1'b1;
		ld_sel <= s;
		ld_val <= v;
		@(posedge clk);
		ld_en <= 1'b0;
	endtask : ld

	// Answer is fixed at one cycle, so no wait loop is needed here
	task automatic op(input logic wr, input logic by,
		input dag_pkg::dag_mode_t m,
		input logic [3:0] s, input logic [15:0] o, input logic [15:0] ea,
		input logic wb, input logic [15:0] nv);
		dag_pkg::dag_req_t c;
		dag_pkg::dag_rsp_t r;
		c = '{valid:1'b1, write:wr, byte_acc:by, mode:m, wsel:s,
			wval:16'h0000, ofs:o};
		@(posedge clk);
		if (wr)
			cmd_wr <= c;
		else
			cmd_rd <= c;
		@(posedge clk);
		cmd_wr <= '0;
		cmd_rd <= '0;
		#1;
		r = wr ? wr_rsp : rd_rsp;
		check({11'h000, r.wb_sel, r.valid, r.ea}, {11'h000, s, 1'b1, ea});
		check({15'h0000, r.wb_en, r.wb_en ? r.wb_val : 16'h0000},
			{15'h0000, wb, wb ? nv : 16'h0000});
	endtask : op

	task automatic t_regs;
		apb(1'b0, dag_pkg::OFF_BREV, 32'h0);
		check(rdat, {16'h0000, dag_pkg::BREV_RST});
		apb(1'b0, dag_pkg::OFF_CIRC, 32'h0);
		check(rdat, {16'h0000, dag_pkg::CIRC_RST});
		apb(1'b1, dag_pkg::OFF_BREV, 32'hffff_8008);
		apb(1'b0, dag_pkg::OFF_BREV, 32'h0);
		check(rdat, 32'h0000_8008);
		apb(1'b0, 8'h40, 32'h0);
		check({rdat[30:0], rerr}, 32'h1);
	endtask : t_regs

	// Buffer at 0x1000 is 32-byte aligned; modifier 8 words
	task automatic t_brev;
		apb(1'b1, dag_pkg::OFF_CIRC, 32'h2);
		ld(2, 16'h1001);
		op(1, 0, dag_pkg::DAG_POST_INC, 2, 2, 16'h1000, 1, 16'h1010);
		apb(1'b0, dag_pkg::OFF_STAT, 32'h0);
		check(rdat, {16'h0000, dag_pkg::STAT_BREV | dag_pkg::STAT_WB});
		op(1, 0, dag_pkg::DAG_POST_INC, 2, 2, 16'h1010, 1, 16'h1008);
		op(1, 0, dag_pkg::DAG_PRE_INC, 2, 2, rev_add(16'h1008, 16'h10), 1,
			rev_add(16'h1008, 16'h10));
		op(0, 0, dag_pkg::DAG_POST_INC, 2, 2, 16'h1018, 1, 16'h101a);
		op(1, 1, dag_pkg::DAG_POST_INC, 2, 1, 16'h101a, 1, 16'h101b);
		op(1, 0, dag_pkg::DAG_POST_DEC, 2, 2, 16'h101b, 1, 16'h1019);
		apb(1'b1, dag_pkg::OFF_CIRC, 32'hf);
		ld(15, 16'h0800);
		op(1, 0, dag_pkg::DAG_POST_INC, 15, 2, 16'h0800, 1, 16'h0802);
		apb(1'b1, dag_pkg::OFF_CIRC, 32'h2);
		apb(1'b1, dag_pkg::OFF_BREV, 32'h0008);
		op(1, 0, dag_pkg::DAG_POST_INC, 2, 2, 16'h1019, 1, 16'h101b);
	endtask : t_brev

	task automatic t_mod;
		apb(1'b1, dag_pkg::OFF_XSTA, 32'h2000);
		apb(1'b1, dag_pkg::OFF_XEND, 32'h201f);
		apb(1'b0, dag_pkg::OFF_XEND, 32'h0);
		check(rdat, 32'h0000_201f);
		apb(1'b1, dag_pkg::OFF_CIRC, 32'h8002);
		apb(1'b1, dag_pkg::OFF_BREV, 32'h8008);
		ld(4, 16'h201e);
		ld(2, 16'h3000);
		op(0, 0, dag_pkg::DAG_POST_INC, 4, 4, 16'h201e, 1, 16'h2000);
		op(0, 0, dag_pkg::DAG_POST_DEC, 4, 4, 16'h2000, 1, 16'h201e);
		op(0, 0, dag_pkg::DAG_REG_OFS, 4, 4, 16'h2002, 0, 16'h0);
		op(1, 0, dag_pkg::DAG_IND, 4, 4, 16'h201e, 0, 16'h0);
		op(1, 0, dag_pkg::DAG_POST_INC, 4, 4, 16'h201e, 1, 16'h2000);
		apb(1'b0, dag_pkg::OFF_STAT, 32'h0);
		check(rdat, {16'h0000, dag_pkg::STAT_WRAP | dag_pkg::STAT_WB});
		op(1, 0, dag_pkg::DAG_POST_INC, 2, 2, 16'h3000, 1, 16'h3010);
		op(0, 0, dag_pkg::DAG_POST_INC, 2, 2, 16'h3010, 1, 16'h2ff2);
	endtask : t_mod

	initial
	begin
		nrst = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		ld_en = 1'b0;
		ld_sel = 4'h0;
		ld_val = 16'h0000;
		cmd_wr = '0;
		cmd_rd = '0;
		mismatches = 0;
		n_compared = 0;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		t_regs;
		t_brev;
		t_mod;
		complete_run;
	end
endmodule : dag_top_bench
